/* File: hdl/spi_cmd_master.sv */
`timescale 1ns/1ps
module spi_cmd_master
  import spi_frame_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Link
  spi_frame_if.host       link,
  // User side
  input  wire logic       start,
  input  wire logic [7:0] tx_byte,
  output logic            busy,
  output logic [7:0]      rx_byte,
  output logic            rx_valid
);

  // ----------------------------------------------------------------
  // Miso synchroniser
  // ----------------------------------------------------------------
  logic [1:0] miso_sync_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      miso_sync_reg <= 2'h0;
    end else begin
      miso_sync_reg <= {miso_sync_reg[0], link.miso};
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  host_state_t state_reg;
  logic [4:0]  wait_reg;
  logic [3:0]  bits_reg;
  logic [7:0]  tx_reg;
  logic [7:0]  rx_reg;
  logic        frame_n_reg;
  logic        sclk_reg;
  logic        mosi_reg;

  // Slow sclk keeps data stable through the slave's synchronisers.
  // Always a full byte per frame, then the strobe-high gap.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= HOST_IDLE;
      wait_reg    <= 5'h00;
      bits_reg    <= 4'h0;
      tx_reg      <= 8'h00;
      rx_reg      <= 8'h00;
      frame_n_reg <= 1'b1;
      sclk_reg    <= 1'b0;
      mosi_reg    <= 1'b0;
      busy        <= 1'b0;
      rx_byte     <= 8'h00;
      rx_valid    <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      case (state_reg)
        HOST_IDLE: begin
          if (start) begin
            frame_n_reg <= 1'b0;
            tx_reg      <= {tx_byte[6:0], 1'b0};
            mosi_reg    <= tx_byte[7];
            bits_reg    <= 4'h0;
            wait_reg    <= {1'b0, SCLK_HALF_CYCLES};
            busy        <= 1'b1;
            state_reg   <= HOST_SETUP;
          end
        end
        HOST_SETUP: begin
          if (wait_reg == 5'h00) begin
            sclk_reg  <= 1'b1;
            wait_reg  <= {1'b0, SCLK_HALF_CYCLES};
            state_reg <= HOST_SHIFT;
          end else begin
            wait_reg <= wait_reg - 5'h01;
          end
        end
        HOST_SHIFT: begin
          if (wait_reg == 5'h00) begin
            sclk_reg <= 1'b0;
            // Bit taken at the end of the high phase: the slave's output
            // trails its clock by the synchronisers and the output flop
            rx_reg   <= {rx_reg[6:0], miso_sync_reg[1]};
            bits_reg <= bits_reg + 4'h1;
            wait_reg <= {1'b0, SCLK_HALF_CYCLES};
            if (bits_reg == BIT_COUNT_FULL - 4'h1) begin
              frame_n_reg <= 1'b1;
              rx_byte     <= {rx_reg[6:0], miso_sync_reg[1]};
              rx_valid    <= 1'b1;
              wait_reg    <= STROBE_HIGH_CYCLES;
              state_reg   <= HOST_GAP;
            end else begin
              mosi_reg  <= tx_reg[7];
              tx_reg    <= {tx_reg[6:0], 1'b0};
              state_reg <= HOST_SETUP;
            end
          end else begin
            wait_reg <= wait_reg - 5'h01;
          end
        end
        HOST_GAP: begin
          if (wait_reg == 5'h00) begin
            busy      <= 1'b0;
            state_reg <= HOST_IDLE;
          end else begin
            wait_reg <= wait_reg - 5'h01;
          end
        end
        default: begin
          state_reg <= HOST_IDLE;
        end
      endcase
    end
  end

  assign link.frame_n = frame_n_reg;
  assign link.sclk    = sclk_reg;
  assign link.mosi    = mosi_reg;

endmodule

/* File: hdl/spi_cmd_slave.sv */
`timescale 1ns/1ps
// Function
// - Strobe falling edge opens a new frame
// - Eight command bits shifted in MSB first
// - Sample rising sclk, change output falling
// - Falling strobe loads held response to shifter
// - Response shifts out MSB first, concurrently
// - Output released whenever strobe is high
// - Short frame discarded without execution
// - Address byte precedes its command byte
// - Illegal command answers with error pattern
module spi_cmd_slave
  import spi_frame_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Link
  spi_frame_if.device     link,
  // User side
  output logic [7:0]      cmd_byte,
  output logic            cmd_valid,
  output logic [7:0]      operand_byte,
  input  wire logic [7:0] resp_byte,
  input  wire logic       resp_valid
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Rising edge between a delayed and a current synchronised level
  function automatic logic edge_up(input logic prev, input logic now);
    return ~prev & now;
  endfunction

  // Falling edge between a delayed and a current synchronised level
  function automatic logic edge_down(input logic prev, input logic now);
    return prev & ~now;
  endfunction

  // One bit enters at the bottom, the top bit drops out
  function automatic logic [7:0] shift_byte(input logic [7:0] b, input logic fill);
    return {b[6:0], fill};
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] frame_sync_reg;
  logic [1:0] sclk_sync_reg;
  logic [1:0] mosi_sync_reg;
  logic       frame_d_reg;
  logic       sclk_d_reg;

  // Strobe resets to its idle high level, so reset makes no false start
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      frame_sync_reg <= 2'h3;
      frame_d_reg    <= 1'b1;
    end else begin
      frame_sync_reg <= {frame_sync_reg[0], link.frame_n};
      frame_d_reg    <= frame_sync_reg[1];
    end
  end

  // Serial clock idles low; the delay stage reads only the second flop
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_sync_reg <= 2'h0;
      sclk_d_reg    <= 1'b0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], link.sclk};
      sclk_d_reg    <= sclk_sync_reg[1];
    end
  end

  // Data input needs no edge finding, only the two flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mosi_sync_reg <= 2'h0;
    end else begin
      mosi_sync_reg <= {mosi_sync_reg[0], link.mosi};
    end
  end

  logic frame_s;
  logic frame_fall;
  logic frame_rise;
  logic sclk_rise;
  logic sclk_fall;

  // Strobe edges in the master clock domain
  assign frame_s    = frame_sync_reg[1];
  assign frame_fall = edge_down(frame_d_reg, frame_s);
  assign frame_rise = edge_up(frame_d_reg, frame_s);

  // Serial clock edges count only inside a frame
  assign sclk_rise  = edge_up(sclk_d_reg, sclk_sync_reg[1]) & ~frame_s;
  assign sclk_fall  = edge_down(sclk_d_reg, sclk_sync_reg[1]) & ~frame_s;

  // ----------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------
  logic [7:0] rx_shift_reg;
  logic [3:0] bit_count_reg;
  logic [7:0] prev_byte_reg;

  // Command shifter and bit counter. A frame longer than eight clocks
  // keeps shifting, so the last eight bits win and still count as full
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_shift_reg  <= CMD_RESET;
      bit_count_reg <= BIT_COUNT_RESET;
    end else if (frame_fall) begin
      bit_count_reg <= BIT_COUNT_RESET;
    end else if (sclk_rise) begin
      rx_shift_reg <= shift_byte(rx_shift_reg, mosi_sync_reg[1]);
      if (bit_count_reg != BIT_COUNT_FULL) begin
        bit_count_reg <= bit_count_reg + 4'h1;
      end
    end
  end

  logic frame_complete;

  // Complete only with a full byte; a short frame is simply dropped
  assign frame_complete = frame_rise && (bit_count_reg == BIT_COUNT_FULL);

  // Remember the last completed byte; it may be an address operand
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prev_byte_reg <= CMD_RESET;
    end else if (frame_complete) begin
      prev_byte_reg <= rx_shift_reg;
    end
  end

  // ----------------------------------------------------------------
  // Execution
  // ----------------------------------------------------------------
  logic [7:0] hold_reg;

  // Execute strobe: one cycle, only after the strobe rises on a full byte
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_valid <= 1'b0;
    end else begin
      cmd_valid <= frame_complete;
    end
  end

  // Command and its operand, latched together at the rising strobe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_byte     <= CMD_RESET;
      operand_byte <= CMD_RESET;
    end else if (frame_complete) begin
      cmd_byte     <= rx_shift_reg;
      operand_byte <= prev_byte_reg;
    end
  end

  // Response holding register; user answers in the same cycle as cmd_valid
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      hold_reg <= RESP_RESET;
    end else if (frame_complete && rx_shift_reg == CMD_ECHO_ADDR) begin
      // Echo answers with the byte of the frame before it
      hold_reg <= prev_byte_reg;
    end else if (cmd_valid && cmd_byte != CMD_ECHO_ADDR) begin
      // User logic flags an illegal command by holding resp_valid low
      hold_reg <= resp_valid ? resp_byte : ERROR_PATTERN;
    end
  end

  // ----------------------------------------------------------------
  // Transmit side
  // ----------------------------------------------------------------
  logic [7:0] tx_shift_reg;
  logic       miso_out_reg;
  logic       miso_oe_reg;

  // Output shifter: loaded at frame start, advanced on falling sclk.
  // The bit moves about three clocks after the fall, so the host must
  // wait at least that long before it takes the bit.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_shift_reg <= RESP_RESET;
      miso_out_reg <= 1'b0;
    end else if (frame_fall) begin
      tx_shift_reg <= shift_byte(hold_reg, 1'b0);
      miso_out_reg <= hold_reg[7];
    end else if (sclk_fall) begin
      miso_out_reg <= tx_shift_reg[7];
      tx_shift_reg <= shift_byte(tx_shift_reg, 1'b0);
    end
  end

  // Drive only inside a frame; release three clocks after the strobe rises
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      miso_oe_reg <= 1'b0;
    end else begin
      miso_oe_reg <= ~frame_s;
    end
  end

  // Pins straight from their flops
  assign link.miso_out = miso_out_reg;
  assign link.miso_oe  = miso_oe_reg;

endmodule

/* File: hdl/spi_frame_if.sv */
`timescale 1ns/1ps
interface spi_frame_if;
  logic frame_n;
  logic sclk;
  logic mosi;
  logic miso_out;
  logic miso_oe;
  logic miso;

  // Resolved line: pulled high when nobody drives
  assign miso = miso_oe ? miso_out : 1'b1;

  modport host (
    output frame_n,
    output sclk,
    output mosi,
    input  miso
  );

  modport device (
    input  frame_n,
    input  sclk,
    input  mosi,
    output miso_out,
    output miso_oe
  );
endinterface

/* File: hdl/spi_frame_pkg.sv */
package spi_frame_pkg;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam int unsigned CMD_BITS        = 8;
  localparam logic [3:0]  BIT_COUNT_FULL  = 4'h8;
  localparam logic [3:0]  BIT_COUNT_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Response values
  // ----------------------------------------------------------------
  localparam logic [7:0] ERROR_PATTERN  = 8'h80;
  localparam logic [7:0] RESP_RESET     = 8'h80;
  localparam logic [7:0] CMD_RESET      = 8'h00;

  // ----------------------------------------------------------------
  // Host timing
  // ----------------------------------------------------------------
  // Serial clock half period is this value plus one master clock: 25 MHz / 10 = 2.5 MHz
  localparam logic [3:0] SCLK_HALF_CYCLES = 4'h4;
  // Least strobe-high time between frames
  localparam int unsigned STROBE_HIGH_NS  = 527;
  localparam int unsigned MCLK_PERIOD_NS  = 40;
  localparam logic [4:0]  STROBE_HIGH_CYCLES =
    5'((STROBE_HIGH_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);

  // Master state machine
  typedef enum logic [3:0] {
    HOST_IDLE  = 4'b0001,
    HOST_SETUP = 4'b0010,
    HOST_SHIFT = 4'b0100,
    HOST_GAP   = 4'b1000
  } host_state_t;

  // Commands of the slave end's own small decoder
  localparam logic [7:0] CMD_ECHO_ADDR = 8'hA5;

  // Operand/address bytes are told apart by the top bit being clear
  function automatic logic is_operand(input logic [7:0] b);
    return ~b[7];
  endfunction

endpackage

/* File: verification/spi_frame_chk.sv */
`timescale 1ns/1ps
module spi_frame_chk
  import spi_frame_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Link lines
  input wire logic frame_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe
);
  // ----
  // Helper counters
  // ----
  logic [3:0] rise_cnt_reg;
  logic [4:0] high_cnt_reg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Serial clock rises seen in the current frame
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      rise_cnt_reg <= 4'h0;
    else if (frame_n)
      rise_cnt_reg <= 4'h0;
    else if ($rose(sclk))
      rise_cnt_reg <= rise_cnt_reg + 4'h1;
  end

  // Strobe high time; starts full so the first frame after reset passes
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      high_cnt_reg <= 5'h1F;
    else if (!frame_n)
      high_cnt_reg <= 5'h00;
    else if (high_cnt_reg != 5'h1F)
      high_cnt_reg <= high_cnt_reg + 5'h01;
  end

  // ----
  // Link properties
  // ----
  a_idle_released: assert property (frame_n [*6] |-> !miso_oe)
    else $error("data output driven while strobe high");
  a_frame_drives: assert property (!frame_n [*6] |-> miso_oe)
    else $error("data output not driven inside frame");
  a_open_drives: assert property ($fell(frame_n) |-> ##[1:5] miso_oe)
    else $error("frame start did not enable output");
  a_open_quiet: assert property ($fell(frame_n) |-> !sclk [*4] ##[1:2] sclk)
    else $error("serial clock timing after frame start wrong");
  a_mosi_steady: assert property ($rose(sclk) |-> $stable(mosi))
    else $error("command bit moved at sampling edge");
  a_miso_steady: assert property ($rose(sclk) && !frame_n |=> $stable(miso_out) [*2])
    else $error("response bit moved after rising clock");
  a_full_bytes: assert property ($rose(frame_n) |-> rise_cnt_reg == BIT_COUNT_FULL)
    else $error("frame closed without eight clocks");
  a_gap_length: assert property ($fell(frame_n) |-> high_cnt_reg >= STROBE_HIGH_CYCLES)
    else $error("strobe high time too short");
  a_idle_clk_low: assert property (frame_n |-> !sclk)
    else $error("serial clock high outside frame");
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import spi_frame_pkg::*;
  // ----
  // Signals and instances
  // ----
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  int miscompares = 0;
  int checks_done = 0;
  logic start = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic [7:0] resp_byte = 8'h00;
  logic resp_valid = 1'b1;
  logic busy;
  logic rx_valid;
  logic cmd_valid;
  logic cmd_valid_b;
  logic [7:0] rx_byte;
  logic [7:0] cmd_byte;
  logic [7:0] cmd_byte_b;
  logic [7:0] operand_byte;
  logic [7:0] last_operand;
  logic [7:0] b_cmds = 8'h00;
  spi_frame_if link_a();
  spi_frame_if link_b();

  always #20 mclk = ~mclk;

  spi_cmd_master spi_cmd_master_i (.mclk(mclk), .reset_n(reset_n), .link(link_a),
    .start(start), .tx_byte(tx_byte), .busy(busy), .rx_byte(rx_byte), .rx_valid(rx_valid));
  spi_cmd_slave spi_cmd_slave_i (.mclk(mclk), .reset_n(reset_n), .link(link_a),
    .cmd_byte(cmd_byte), .cmd_valid(cmd_valid), .operand_byte(operand_byte),
    .resp_byte(resp_byte), .resp_valid(resp_valid));
  // Second end faces the bench's own deliberately faulty host
  spi_cmd_slave spi_cmd_slave_b_i (.mclk(mclk), .reset_n(reset_n), .link(link_b),
    .cmd_byte(cmd_byte_b), .cmd_valid(cmd_valid_b), .operand_byte(),
    .resp_byte(8'h00), .resp_valid(1'b1));
  spi_frame_chk spi_frame_chk_i (.mclk(mclk), .reset_n(reset_n), .frame_n(link_a.frame_n),
    .sclk(link_a.sclk), .mosi(link_a.mosi), .miso_out(link_a.miso_out),
    .miso_oe(link_a.miso_oe));

  // Executed commands on the second end
  always @(negedge mclk)
    if (cmd_valid_b === 1'b1)
      b_cmds <= b_cmds + 8'h01;

  // ----
  // Shared tasks
  // ----
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One frame through the master; bounded waits so a dead end cannot hang
  task automatic xfer(input logic [7:0] tx, input logic [7:0] resp, input logic ok,
                      input logic [7:0] exp_rx);
    int n;
    @(posedge mclk);
    start <= 1'b1;
    tx_byte <= tx;
    resp_byte <= resp;
    resp_valid <= ok;
    @(posedge mclk);
    start <= 1'b0;
    for (n = 0; n < 200 && rx_valid !== 1'b1; n++)
      @(negedge mclk);
    check8(rx_byte, exp_rx, "response");
    for (n = 0; n < 20 && cmd_valid !== 1'b1; n++)
      @(negedge mclk);
    last_operand = operand_byte;
    check8(cmd_byte, tx, "command");
    for (n = 0; n < 40 && busy !== 1'b0; n++)
      @(negedge mclk);
  endtask

  // Bench-made host on the second link; reads each bit just before the falling clock
  task automatic frame_b(input int nbits, input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    @(posedge mclk);
    link_b.frame_n <= 1'b0;
    link_b.mosi    <= tx[7];
    repeat (4) @(posedge mclk);
    check8({7'h00, link_b.miso_oe}, 8'h01, "output enable in frame");
    for (int i = 0; i < nbits; i++) begin
      link_b.sclk <= 1'b1;
      repeat (4) @(posedge mclk);
      rx = {rx[6:0], link_b.miso};
      link_b.sclk <= 1'b0;
      link_b.mosi <= (i < 7) ? tx[6 - i] : ~link_b.mosi;
      repeat (4) @(posedge mclk);
    end
    link_b.frame_n <= 1'b1;
    link_b.mosi    <= ~link_b.mosi;
    repeat (16) @(posedge mclk);
    check8({7'h00, link_b.miso}, 8'h01, "released line");
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_pipeline();
    xfer(8'h3C, 8'h5A, 1'b1, RESP_RESET);
    xfer(8'hC3, 8'hFF, 1'b1, 8'h5A);
    xfer(8'h01, 8'h00, 1'b1, 8'hFF);
  endtask

  task automatic t_illegal();
    xfer(8'hFE, 8'h81, 1'b0, 8'h00);
    xfer(8'h2B, 8'h11, 1'b1, ERROR_PATTERN);
  endtask

  task automatic t_echo();
    xfer(CMD_ECHO_ADDR, 8'h22, 1'b1, 8'h11);
    check8(last_operand, 8'h2B, "operand");
    xfer(8'h7E, 8'h33, 1'b1, 8'h2B);
  endtask

  task automatic t_short_frame();
    logic [7:0] rx;
    frame_b(5, 8'hF0, rx);
    check8(b_cmds, 8'h00, "short frame executed");
    frame_b(8, 8'h96, rx);
    check8(rx, RESP_RESET, "response after short frame");
    check8(b_cmds, 8'h01, "full frame count");
    check8(cmd_byte_b, 8'h96, "bit-banged command");
    frame_b(8, 8'h0F, rx);
    check8(rx, 8'h00, "next response");
  endtask

  task automatic end_sim();
    $display("Checks: %0d, mismatches: %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog well past the roughly 930 cycles the run needs
  initial begin
    repeat (10000) @(posedge mclk);
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end

  // Main sequence
  initial begin
    link_b.frame_n <= 1'b1;
    link_b.sclk    <= 1'b0;
    link_b.mosi    <= 1'b0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_pipeline();
    t_illegal();
    t_echo();
    t_short_frame();
    end_sim();
  end
endmodule
